/* verilog/scm_top.sv */
// mode, clock selection and sticky error flags of a serial channel
// assumes shift engine supplies one-cycle error pulses and baud ticks
// Operation
// RULE1 - parity enable at bit 5, read/write, turns UART parity on or off
// RULE2 - parity applies only in 7-bit or 8-bit UART data length
// RULE3 - read-only overrun flag at bit 4 set when a character is lost
// RULE4 - bit 3 flags receive parity mismatch or clocked-mode underrun
// RULE5 - read-only framing flag at bit 2 set on missing stop bit
// RULE6 - bit 1 picks rising (0) or falling (1) input clock edge
// RULE7 - software keeps edge select 0 when channel drives its clock out
// RULE8 - bit 0 value 0 takes clocked-mode clock from baud generator
// RULE9 - bit 0 value 1 takes external pin clock on the chosen edge
// RULE10 - error flags clear after a register read; writes leave them
`timescale 1ns/1ps
module scm_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic io_mode_in,
  input wire scm_pkg::scm_len_type data_len_in,
  input wire logic overrun_event_in,
  input wire logic parity_event_in,
  input wire logic underrun_event_in,
  input wire logic framing_event_in,
  input wire logic baud_tick_in,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n_out,
  output logic parity_active_out,
  output logic shift_tick_out,
  output scm_pkg::scm_cfg_type cfg_out
);
  import scm_pkg::*;

  scm_cfg_type cfg_q;
  scm_cfg_type cfg_d;
  scm_err_type err_q;
  scm_err_type err_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic sclk_q;
  logic sclk_d;
  logic pin_rise;
  logic pin_fall;
  logic [7:0] image;

  //////////////////////////////////////////////////////////////////////
  // register image and software access

  always_comb begin
    image = 8'h00;
    image[scm_parity_enable_bit] = cfg_q.parity_enable;
    image[scm_overrun_bit] = err_q.overrun_error_flag;
    image[scm_parity_underrun_bit] = err_q.parity_underrun_error_flag;
    image[scm_framing_bit] = err_q.framing_error_flag;
    image[scm_clock_edge_bit] = cfg_q.clock_edge_select;
    image[scm_clock_source_bit] = cfg_q.clock_source_select;
  end

  always_comb begin
    cfg_d = cfg_q;
    if (wr_en_in) begin
      cfg_d.parity_enable = wr_data_in[scm_parity_enable_bit]; // RULE1
      cfg_d.clock_edge_select = wr_data_in[scm_clock_edge_bit]; // RULE6
      cfg_d.clock_source_select = wr_data_in[scm_clock_source_bit]; // RULE8
    end
    rd_data_d = rd_en_in ? image : rd_data_q;
    // read clears first, then fresh events set: a read in the same cycle never loses an event
    err_d = err_q;
    if (rd_en_in) begin
      err_d = '0; // RULE10
    end
    if (overrun_event_in) begin
      err_d.overrun_error_flag = 1'h1; // RULE3
    end
    if ((parity_event_in && !io_mode_in) ||
        (underrun_event_in && io_mode_in)) begin
      err_d.parity_underrun_error_flag = 1'h1; // RULE4
    end
    if (framing_event_in) begin
      err_d.framing_error_flag = 1'h1; // RULE5
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q.parity_enable <= scm_parity_enable_rst;
      cfg_q.clock_edge_select <= scm_clock_edge_rst;
      cfg_q.clock_source_select <= scm_clock_source_rst;
      err_q <= {3{scm_flag_rst}};
      rd_data_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      err_q <= err_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data_out = rd_data_q;
  assign cfg_out = cfg_q;

  //////////////////////////////////////////////////////////////////////
  // parity qualification

  // nine-bit and other lengths use the spare bit for data, not parity
  assign parity_active_out = cfg_q.parity_enable && !io_mode_in &&
    (data_len_in == scm_len_7bit || data_len_in == scm_len_8bit); // RULE2

  //////////////////////////////////////////////////////////////////////
  // serial clock selection

  scm_edge_det scm_edge_det_i (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sig_in(sclk_in),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  always_comb begin
    sclk_d = sclk_q;
    if (io_mode_in && !cfg_q.clock_source_select && baud_tick_in) begin
      sclk_d = ~sclk_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_q <= 1'h0;
    end else begin
      sclk_q <= sclk_d;
    end
  end

  always_comb begin
    shift_tick_out = baud_tick_in; // RULE8
    if (io_mode_in && cfg_q.clock_source_select) begin
      shift_tick_out = cfg_q.clock_edge_select ? pin_fall : pin_rise; // RULE9
    end
  end

  // driving the clock out relies on edge select being left at zero
  assign sclk_out = sclk_q; // RULE7
  assign sclk_oe_n_out = ~(io_mode_in && !cfg_q.clock_source_select);

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  par_active_a: assert property (parity_active_out == // RULE2
    (cfg_q.parity_enable && !io_mode_in &&
    data_len_in inside {scm_len_7bit, scm_len_8bit}))
    else $error("parity qualification wrong");
  par_io_a: assert property (io_mode_in |-> // RULE2
    !parity_active_out)
    else $error("parity active in clocked mode");
  par_write_a: assert property (wr_en_in |=> // RULE1
    cfg_out.parity_enable == $past(wr_data_in[scm_parity_enable_bit]))
    else $error("parity enable not written");
  wr_edge_a: assert property (wr_en_in |=> // RULE6
    cfg_out.clock_edge_select == $past(wr_data_in[scm_clock_edge_bit]))
    else $error("edge select not written");
  wr_src_a: assert property (wr_en_in |=> // RULE8
    cfg_out.clock_source_select ==
    $past(wr_data_in[scm_clock_source_bit]))
    else $error("source select not written");
  ovr_set_a: assert property (overrun_event_in ##1 rd_en_in |=> // RULE3
    rd_data_out[scm_overrun_bit])
    else $error("overrun flag missed");
  // a flag stands until a read takes it
  ovr_hold_a: assert property (err_q.overrun_error_flag && // RULE3
    !rd_en_in |=> err_q.overrun_error_flag)
    else $error("overrun flag dropped");
  pu_set_a: assert property ((parity_event_in && !io_mode_in) || // RULE4
    (underrun_event_in && io_mode_in) |=> err_q.parity_underrun_error_flag)
    else $error("parity or underrun flag missed");
  pu_mode_a: assert property (!rd_en_in && // RULE4
    !err_q.parity_underrun_error_flag &&
    !(parity_event_in && !io_mode_in) && !(underrun_event_in &&
    io_mode_in) |=> !err_q.parity_underrun_error_flag)
    else $error("bit 3 set without cause");
  pu_hold_a: assert property (err_q.parity_underrun_error_flag && // RULE4
    !rd_en_in |=> err_q.parity_underrun_error_flag)
    else $error("parity or underrun flag dropped");
  fe_set_a: assert property (framing_event_in |=> // RULE5
    err_q.framing_error_flag)
    else $error("framing flag missed");
  fe_hold_a: assert property (err_q.framing_error_flag && // RULE5
    !rd_en_in |=> err_q.framing_error_flag)
    else $error("framing flag dropped");
  edge_pick_a: assert property (io_mode_in && // RULE6
    cfg_q.clock_source_select && $fell(sclk_in) |->
    shift_tick_out == cfg_q.clock_edge_select)
    else $error("wrong external edge");
  src_int_a: assert property (!(io_mode_in && // RULE8
    cfg_q.clock_source_select) |-> shift_tick_out == baud_tick_in)
    else $error("internal clock not used");
  // the outgoing clock moves on baud ticks only
  sclk_tog_a: assert property (io_mode_in && // RULE8
    !cfg_q.clock_source_select && baud_tick_in |=>
    sclk_out != $past(sclk_out))
    else $error("internal clock did not toggle");
  sclk_hold_a: assert property (!(io_mode_in && // RULE8
    !cfg_q.clock_source_select && baud_tick_in) |=> $stable(sclk_out))
    else $error("internal clock moved without tick");
  ext_rise_a: assert property (io_mode_in && // RULE9
    cfg_q.clock_source_select && !cfg_q.clock_edge_select |->
    shift_tick_out == $rose(sclk_in))
    else $error("external rising edge not used");
  ext_fall_a: assert property (io_mode_in && // RULE9
    cfg_q.clock_source_select && cfg_q.clock_edge_select |->
    shift_tick_out == $fell(sclk_in))
    else $error("external falling edge not used");
  rd_clr_a: assert property (rd_en_in && !overrun_event_in && // RULE10
    !framing_event_in && !parity_event_in && !underrun_event_in
    |=> err_q == '0)
    else $error("flags not cleared by read");
  wr_keep_a: assert property (wr_en_in && !rd_en_in && // RULE10
    !overrun_event_in && !framing_event_in && !parity_event_in &&
    !underrun_event_in |=> $stable(err_q))
    else $error("write changed a flag");
  rd_image_a: assert property (rd_en_in |=> rd_data_out == // RULE10
    {2'h0, $past(cfg_q.parity_enable), $past(err_q),
    $past(cfg_q.clock_edge_select), $past(cfg_q.clock_source_select)})
    else $error("read image wrong");

  ovr_clear_c: cover property (overrun_event_in ##1 rd_en_in ##1
    !err_q.overrun_error_flag);
  set_on_clr_c: cover property (rd_en_in && framing_event_in);
  ext_fall_c: cover property (io_mode_in && cfg_q.clock_source_select &&
    cfg_q.clock_edge_select && shift_tick_out);
  sclk_drive_c: cover property (!sclk_oe_n_out && $changed(sclk_out));
endmodule

/* verilog/scm_pkg.sv */
// constants and carrier types for the serial channel mode/error block
// assumes a single 100 MHz system clock and plain-port software access
package scm_pkg;
  localparam int unsigned scm_reg_width = 8;
  localparam int unsigned scm_parity_enable_bit = 5;
  localparam int unsigned scm_overrun_bit = 4;
  localparam int unsigned scm_parity_underrun_bit = 3;
  localparam int unsigned scm_framing_bit = 2;
  localparam int unsigned scm_clock_edge_bit = 1;
  localparam int unsigned scm_clock_source_bit = 0;
  localparam logic scm_parity_enable_rst = 1'h0;
  localparam logic scm_clock_edge_rst = 1'h0;
  localparam logic scm_clock_source_rst = 1'h0;
  localparam logic scm_flag_rst = 1'h0;

  typedef enum logic [1:0] {
    scm_len_7bit = 2'h0,
    scm_len_8bit = 2'h1,
    scm_len_9bit = 2'h2,
    scm_len_other = 2'h3
  } scm_len_type;

  typedef struct packed {
    logic parity_enable;
    logic clock_edge_select;
    logic clock_source_select;
  } scm_cfg_type;

  typedef struct packed {
    logic overrun_error_flag;
    logic parity_underrun_error_flag;
    logic framing_error_flag;
  } scm_err_type;
endpackage

/* verilog/scm_edge_det.sv */
// edge detector for a pin already synchronous to the system clock
// assumes sig_in changes only on clk_in edges
`timescale 1ns/1ps
module scm_edge_det (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sig_in,
  output logic rise_out,
  output logic fall_out
);
  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = sig_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_q <= 1'h0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise_out = sig_in & ~prev_q;
  assign fall_out = ~sig_in & prev_q;
endmodule

/* bench/scm_peer.sv */
// far-side serial peer: drives the external serial clock pin
// assumes the bench enables it only inside clocked-mode frames
`timescale 1ns/1ps
module scm_peer (
  input wire logic clk_in,
  input wire logic run_in,
  output logic sclk_out
);
  logic [1:0] cnt;
  initial begin
    cnt = 2'h0;
    sclk_out = 1'h0;
  end
  // clock stands low between frames, toggles every two cycles within
  always @(posedge clk_in) begin
    cnt <= #1 run_in ? cnt + 2'h1 : 2'h0;
    if (!run_in)
      sclk_out <= #1 1'h0;
    else if (cnt[0])
      sclk_out <= #1 ~sclk_out;
  end
endmodule

/* bench/scm_top_tb.sv */
// self-checking bench for the serial channel mode/error block
// assumes scm_peer drives the external clock pin
`timescale 1ns/1ps
module scm_top_tb;
  import scm_pkg::*;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic wr_en_in = 1'h0;
  logic rd_en_in = 1'h0;
  logic [7:0] wr_data_in = 8'h00;
  logic [7:0] rd_data_out;
  logic io_mode_in = 1'h0;
  scm_len_type data_len_in = scm_len_7bit;
  logic [3:0] ev = 4'h0;
  logic baud_tick_in = 1'h0;
  logic run = 1'h0;
  logic sclk_in, sclk_out, sclk_oe_n_out, parity_active_out;
  logic shift_tick_out, b, prv;
  scm_cfg_type cfg_out;
  int n_errors = 0;
  int n_checks = 0;

  always #5 clk_in = ~clk_in;

  scm_top scm_top_i (.clk_in(clk_in), .rst_in(rst_in),
    .wr_en_in(wr_en_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .io_mode_in(io_mode_in),
    .data_len_in(data_len_in), .overrun_event_in(ev[3]),
    .parity_event_in(ev[2]), .underrun_event_in(ev[1]),
    .framing_event_in(ev[0]), .baud_tick_in(baud_tick_in),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_n_out(sclk_oe_n_out),
    .parity_active_out(parity_active_out),
    .shift_tick_out(shift_tick_out), .cfg_out(cfg_out));
  scm_peer scm_peer_i (.clk_in(clk_in), .run_in(run), .sclk_out(sclk_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    wr_en_in = 1'h1;
    wr_data_in = d;
    step;
    wr_en_in = 1'h0;
  endtask
  task automatic rd(input logic [7:0] exp);
    rd_en_in = 1'h1;
    step;
    rd_en_in = 1'h0;
    chk(rd_data_out, exp);
    // an edge passes so back-to-back reads never rewrite the strobe
    step;
  endtask
  task automatic evp(input logic [3:0] e);
    ev = e;
    step;
    ev = 4'h0;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    end_sim;
  end

  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 1'h0;
    rd(8'h00);
    wr(8'hff);
    chk({5'h00, cfg_out}, 8'h07);
    rd(8'h23);
    for (int i = 0; i < 8; i++) begin
      data_len_in = scm_len_type'(i[1:0]);
      io_mode_in = i[2];
      step;
      chk({7'h00, parity_active_out}, {7'h00, i < 2});
    end
    io_mode_in = 1'h0;
    evp(4'h8);
    rd(8'h33);
    evp(4'h4);
    rd(8'h2b);
    evp(4'h1);
    wr(8'h23);
    rd(8'h27);
    evp(4'h2);
    rd(8'h23);
    io_mode_in = 1'h1;
    evp(4'h2);
    rd(8'h2b);
    rd(8'h23);
    evp(4'h4);
    rd(8'h23);
    // event in the same cycle as a read: the set wins
    ev = 4'h1;
    rd(8'h23);
    ev = 4'h0;
    rd(8'h27);
    // internal source with edge select 0, as the clock goes out
    baud_tick_in = 1'h1;
    wr(8'h20);
    chk({7'h00, sclk_oe_n_out}, 8'h00);
    chk({7'h00, shift_tick_out}, 8'h01);
    b = sclk_out;
    step;
    chk({7'h00, sclk_out}, {7'h00, ~b});
    // baud ticks held high must not leak through with the pin clock
    for (int e = 0; e < 2; e++) begin
      wr(e ? 8'h23 : 8'h21);
      chk({7'h00, sclk_oe_n_out}, 8'h01);
      run = 1'h1;
      prv = sclk_in;
      repeat (24) begin
        @(negedge clk_in);
        b = e ? prv & ~sclk_in : sclk_in & ~prv;
        chk({7'h00, shift_tick_out}, {7'h00, b});
        prv = sclk_in;
      end
      step;
      run = 1'h0;
      repeat (2) step;
    end
    end_sim;
  end
endmodule
